/* File: src/psds_axil_slave.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// AXI4-Lite slave for the two control registers
// ----------------------------------------------------------------------
module psds_axil_slave
  import psds_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [7:0]       ctrl_a,
  output logic [7:0]       ctrl_b
);

  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_addr;
  logic [7:0]  w_byte;
  logic        w_lane;
  logic        next_aw_held;
  logic        next_w_held;
  logic [3:0]  next_aw_addr;
  logic [7:0]  next_w_byte;
  logic        next_w_lane;
  logic [7:0]  next_ctrl_a;
  logic [7:0]  next_ctrl_b;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        do_write;

  // Channels accepted independently; held until the response drains
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Write path next state
  always_comb
  begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_byte  = w_byte;
    next_w_lane  = w_lane;
    next_ctrl_a  = ctrl_a;
    next_ctrl_b  = ctrl_b;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_byte = s_axi_wdata[7:0];
      next_w_lane = s_axi_wstrb[0];
    end
    do_write = next_aw_held && next_w_held && !s_axi_bvalid;
    if (do_write)
    begin
      // Unused bits masked so they stay zero
      next_bresp = PSDS_RESP_OKAY;
      if (next_aw_addr == PSDS_ADDR_CTRL_A)
      begin
        if (next_w_lane)
          next_ctrl_a = next_w_byte & PSDS_MASK_CTRL_A;
      end
      else if (next_aw_addr == PSDS_ADDR_CTRL_B)
      begin
        if (next_w_lane)
          next_ctrl_b = next_w_byte & PSDS_MASK_CTRL_B;
      end
      else
        next_bresp = PSDS_RESP_SLVERR;
      next_bvalid  = 1'b1;
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
    end
    else if (s_axi_bvalid && s_axi_bready)
      next_bvalid = 1'b0;
  end

  // Read path next state
  always_comb
  begin
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = PSDS_RESP_OKAY;
      if (s_axi_araddr == PSDS_ADDR_CTRL_A)
        next_rdata = {24'h000000, ctrl_a};
      else if (s_axi_araddr == PSDS_ADDR_CTRL_B)
        next_rdata = {24'h000000, ctrl_b};
      else
      begin
        next_rdata = 32'h00000000;
        next_rresp = PSDS_RESP_SLVERR;
      end
    end
    else if (s_axi_rvalid && s_axi_rready)
      next_rvalid = 1'b0;
  end

  // Registers; high-voltage static bit resets on
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 4'h0;
      w_byte       <= 8'h00;
      w_lane       <= 1'b0;
      ctrl_a       <= PSDS_RESET_CTRL_A;
      ctrl_b       <= PSDS_RESET_CTRL_B;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end
    else
    begin
      aw_held      <= next_aw_held;
      w_held       <= next_w_held;
      aw_addr      <= next_aw_addr;
      w_byte       <= next_w_byte;
      w_lane       <= next_w_lane;
      ctrl_a       <= next_ctrl_a;
      ctrl_b       <= next_ctrl_b;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end
  end

endmodule
`default_nettype wire

/* File: src/psds_drive_mux.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// One registered source selector for a switch drive
// ----------------------------------------------------------------------
module psds_drive_mux
  import psds_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire psds_src_t  sel,
  input  wire logic       static_on,
  input  wire logic [2:0] timer_pwm,
  input  wire logic       reset_level,
  output logic            drive
);

  logic next_drive;

  // Static bit on code zero, else the chosen timer PWM
  always_comb
  begin
    case (sel)
      PSDS_SRC_STATIC: next_drive = static_on;
      PSDS_SRC_TIMER0: next_drive = timer_pwm[0];
      PSDS_SRC_TIMER1: next_drive = timer_pwm[1];
      PSDS_SRC_TIMER2: next_drive = timer_pwm[2];
      default:         next_drive = static_on;
    endcase
  end

  // Flop the drive so decode hazards never reach the gate
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      drive <= 1'b0;
    else
      drive <= next_drive;
  end

endmodule
`default_nettype wire

/* File: src/psds_pkg.sv */
// ----------------------------------------------------------------------
// Shared constants and types
// ----------------------------------------------------------------------
package psds_pkg;

  // Byte addresses of the two control registers
  localparam logic [3:0] PSDS_ADDR_CTRL_A = 4'h0;
  localparam logic [3:0] PSDS_ADDR_CTRL_B = 4'h4;

  // Reset values
  localparam logic [7:0] PSDS_RESET_CTRL_A = 8'h01;
  localparam logic [7:0] PSDS_RESET_CTRL_B = 8'h00;

  // Writable bit masks; the unused bit of each register is cleared
  localparam logic [7:0] PSDS_MASK_CTRL_A = 8'hBF;
  localparam logic [7:0] PSDS_MASK_CTRL_B = 8'h7F;

  // Field positions in control register a
  localparam int PSDS_A_DIV_SENSE = 7;
  localparam int PSDS_A_LAMP_SEL  = 4;
  localparam int PSDS_A_LAMP_ON   = 3;
  localparam int PSDS_A_OC_SEL    = 1;
  localparam int PSDS_A_HV_ON     = 0;

  // Field positions in control register b
  localparam int PSDS_B_HV_SEL    = 5;
  localparam int PSDS_B_HS_EN     = 4;
  localparam int PSDS_B_LS_EN     = 3;
  localparam int PSDS_B_SND_SEL   = 1;
  localparam int PSDS_B_SND_ON    = 0;

  // AXI response codes
  localparam logic [1:0] PSDS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PSDS_RESP_SLVERR = 2'h2;

  // Source selection codes
  typedef enum logic [1:0]
  {
    PSDS_SRC_STATIC = 2'h0,
    PSDS_SRC_TIMER0 = 2'h1,
    PSDS_SRC_TIMER1 = 2'h2,
    PSDS_SRC_TIMER2 = 2'h3
  } psds_src_t;

  // Overcurrent sense input codes
  typedef enum logic [1:0]
  {
    PSDS_OC_PIN0 = 2'h0,
    PSDS_OC_PIN1 = 2'h1,
    PSDS_OC_TAP  = 2'h2
  } psds_oc_t;

  // Decoded control fields handed to the drive logic
  typedef struct packed
  {
    logic      divider_sense_enable;
    psds_src_t lamp_sel;
    logic      lamp_static_on;
    logic [1:0] oc_sel;
    logic      high_voltage_static_on;
    psds_src_t hv_sel;
    logic      boost_high_side_gate_enable;
    logic      boost_low_side_gate_enable;
    psds_src_t sounder_sel;
    logic      sounder_static_on;
  } psds_ctrl_t;

  // Three timer PWM outputs plus timer zero complementary pair
  typedef struct packed
  {
    logic [2:0] timer_pwm;
    logic       timer_high_side_pwm;
    logic       timer_low_side_pwm;
  } psds_pwm_t;

endpackage

/* File: src/psds_top.sv */
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Divider-sense bit connects feedback resistor divider
// - Lamp select: static, timer zero, one, two
// - Lamp static mode follows lamp static bit
// - High-voltage select: static or timer zero/one/two
// - High-voltage static bit, resets to one
// - Sounder select: static or timer zero/one/two
// - Sounder static mode gives constant level
// - High-side drive forced high unless enabled
// - Boost drive only from timer zero pair
// - Low-side drive forced low unless enabled
// - Unused register bits read zero
// - Sounder drives two switches together
// - Lamp switch gated by selected lamp drive
// - Overcurrent input: pin0, pin1, or resistor tap
module psds_top
  import psds_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire psds_pwm_t   pwm_in,
  output logic             high_voltage_enable,
  output logic             lamp_power_switch,
  output logic             sounder_switch_a,
  output logic             sounder_switch_b,
  output logic             boost_high_side_drive,
  output logic             boost_low_side_drive,
  output logic             divider_sense_enable,
  output logic             overcurrent_sel_pin0,
  output logic             overcurrent_sel_pin1,
  output logic             overcurrent_sel_tap
);

  logic [7:0]  ctrl_a;
  logic [7:0]  ctrl_b;
  psds_ctrl_t  ctrl;
  logic        sounder_drive;
  logic        lamp_drive;
  logic        next_hs;
  logic        next_ls;
  logic        next_div;
  logic [2:0]  next_oc;
  logic [2:0]  oc_onehot;

  // --------------------------------------------------------------------
  // Register access
  // --------------------------------------------------------------------
  psds_axil_slave u_regs
  (
    .sys_clk       (sys_clk),
    .resetn        (resetn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .ctrl_a        (ctrl_a),
    .ctrl_b        (ctrl_b)
  );

  // Field decode of both registers
  always_comb
  begin
    ctrl.divider_sense_enable        = ctrl_a[PSDS_A_DIV_SENSE];
    ctrl.lamp_sel    = psds_src_t'(ctrl_a[PSDS_A_LAMP_SEL +: 2]);
    ctrl.lamp_static_on              = ctrl_a[PSDS_A_LAMP_ON];
    ctrl.oc_sel                      = ctrl_a[PSDS_A_OC_SEL +: 2];
    ctrl.high_voltage_static_on      = ctrl_a[PSDS_A_HV_ON];
    ctrl.hv_sel      = psds_src_t'(ctrl_b[PSDS_B_HV_SEL +: 2]);
    ctrl.boost_high_side_gate_enable = ctrl_b[PSDS_B_HS_EN];
    ctrl.boost_low_side_gate_enable  = ctrl_b[PSDS_B_LS_EN];
    ctrl.sounder_sel = psds_src_t'(ctrl_b[PSDS_B_SND_SEL +: 2]);
    ctrl.sounder_static_on           = ctrl_b[PSDS_B_SND_ON];
  end

  // --------------------------------------------------------------------
  // Source selectors
  // --------------------------------------------------------------------
  // High-voltage enable; reset_level is tied on but unused, so the drive resets low until the static bit loads
  psds_drive_mux u_hv_mux
  (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .sel         (ctrl.hv_sel),
    .static_on   (ctrl.high_voltage_static_on),
    .timer_pwm   (pwm_in.timer_pwm),
    .reset_level (1'b1),
    .drive       (high_voltage_enable)
  );

  // Lamp drive gates the lamp supply switch
  psds_drive_mux u_lamp_mux
  (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .sel         (ctrl.lamp_sel),
    .static_on   (ctrl.lamp_static_on),
    .timer_pwm   (pwm_in.timer_pwm),
    .reset_level (1'b0),
    .drive       (lamp_drive)
  );

  // Sounder drive, steady level in static mode
  psds_drive_mux u_snd_mux
  (
    .sys_clk     (sys_clk),
    .resetn      (resetn),
    .sel         (ctrl.sounder_sel),
    .static_on   (ctrl.sounder_static_on),
    .timer_pwm   (pwm_in.timer_pwm),
    .reset_level (1'b0),
    .drive       (sounder_drive)
  );

  assign lamp_power_switch = lamp_drive;
  assign sounder_switch_a  = sounder_drive;
  assign sounder_switch_b  = sounder_drive;

  // --------------------------------------------------------------------
  // Boost pair, divider and overcurrent selection
  // --------------------------------------------------------------------
  // Only timer zero's pair can reach the boost switches
  always_comb
  begin
    next_hs = ctrl.boost_high_side_gate_enable ?
              pwm_in.timer_high_side_pwm : 1'b1;
    next_ls = ctrl.boost_low_side_gate_enable ?
              pwm_in.timer_low_side_pwm : 1'b0;
    next_div = ctrl.divider_sense_enable;
    case (ctrl.oc_sel)
      PSDS_OC_PIN0: next_oc = 3'h1;
      PSDS_OC_PIN1: next_oc = 3'h2;
      default:      next_oc = 3'h4;
    endcase
  end

  // All drives registered: one cycle after the write, glitch free
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      boost_high_side_drive <= 1'b1;
      boost_low_side_drive  <= 1'b0;
      divider_sense_enable  <= 1'b0;
      oc_onehot             <= 3'h1;
    end
    else
    begin
      boost_high_side_drive <= next_hs;
      boost_low_side_drive  <= next_ls;
      divider_sense_enable  <= next_div;
      oc_onehot             <= next_oc;
    end
  end

  assign overcurrent_sel_pin0 = oc_onehot[0];
  assign overcurrent_sel_pin1 = oc_onehot[1];
  assign overcurrent_sel_tap  = oc_onehot[2];

endmodule
`default_nettype wire

/* File: tb/psds_timer_model.sv */
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------
// Timer module pwm outputs
// --------------------------------------
module psds_timer_model
  import psds_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       resetn,
  input  wire logic       run,
  input  wire logic [4:0] pattern,
  output var psds_pwm_t   pwm_out
);
  // Running count gives each output its own rate; else hold pattern
  // Cast back to the carrier so the count never pads or drops a bit
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      pwm_out <= psds_pwm_t'(5'h00);
    else if (run)
      pwm_out <= psds_pwm_t'(5'(pwm_out + 5'h01));
    else
      pwm_out <= psds_pwm_t'(pattern);
  end
endmodule
`default_nettype wire

/* File: tb/psds_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------
// Port properties of the drive select
// --------------------------------------
module psds_top_props
  import psds_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire psds_pwm_t   pwm_in,
  input wire logic        sounder_switch_a,
  input wire logic        sounder_switch_b,
  input wire logic        boost_high_side_drive,
  input wire logic        boost_low_side_drive,
  input wire logic        overcurrent_sel_pin0,
  input wire logic        overcurrent_sel_pin1,
  input wire logic        overcurrent_sel_tap
);
  default clocking dcb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  // Switch drives against their sources
  a_sounder_pair: assert property (
    sounder_switch_a == sounder_switch_b)
    else $error("sounder switches differ");
  a_oc_onehot: assert property (
    $onehot({overcurrent_sel_pin0, overcurrent_sel_pin1, overcurrent_sel_tap}))
    else $error("overcurrent select not one-hot");
  // Boost low only when timer zero high side was low
  a_high_side_src: assert property (
    !boost_high_side_drive |-> !$past(pwm_in.timer_high_side_pwm))
    else $error("high side drive low without its pwm");
  a_low_side_src: assert property (
    boost_low_side_drive |-> $past(pwm_in.timer_low_side_pwm))
    else $error("low side drive high without its pwm");

  // Bus answers
  a_rdata_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_bresp_drop: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not retired");
  a_rresp_drop: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response not retired");
endmodule

bind psds_top psds_top_props i_props (
  .sys_clk(sys_clk), .resetn(resetn), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .pwm_in(pwm_in),
  .sounder_switch_a(sounder_switch_a), .sounder_switch_b(sounder_switch_b),
  .boost_high_side_drive(boost_high_side_drive),
  .boost_low_side_drive(boost_low_side_drive),
  .overcurrent_sel_pin0(overcurrent_sel_pin0),
  .overcurrent_sel_pin1(overcurrent_sel_pin1),
  .overcurrent_sel_tap(overcurrent_sel_tap));
`default_nettype wire

/* File: tb/tb_power_switch_drive_select.sv */
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------
// Self-checking bench
// --------------------------------------
module tb_power_switch_drive_select;
  import psds_pkg::*;
  localparam logic [3:0] adr_a = PSDS_ADDR_CTRL_A;
  localparam logic [3:0] adr_b = PSDS_ADDR_CTRL_B;
  logic        sys_clk = 1'h0;
  logic        resetn = 1'h0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0, run = 1'h0;
  logic [4:0]  pattern = 5'h00;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata, rd;
  psds_pwm_t   pwm_in;
  logic        hv, lamp, snd_a, snd_b, bh, bl, dsen, oc0, oc1, oct;
  int          errors = 0;
  int          checks_done = 0;

  // Free-running 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  psds_top i_dut (
    .sys_clk(sys_clk), .resetn(resetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pwm_in(pwm_in),
    .high_voltage_enable(hv), .lamp_power_switch(lamp),
    .sounder_switch_a(snd_a), .sounder_switch_b(snd_b),
    .boost_high_side_drive(bh), .boost_low_side_drive(bl),
    .divider_sense_enable(dsen), .overcurrent_sel_pin0(oc0),
    .overcurrent_sel_pin1(oc1), .overcurrent_sel_tap(oct));

  psds_timer_model i_timers (
    .sys_clk(sys_clk), .resetn(resetn), .run(run), .pattern(pattern),
    .pwm_out(pwm_in));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // A stuck handshake ends the run as a failure
  task automatic hang();
    errors++;
    test_done();
  endtask

  // Ready is combinational, so handshakes are judged at the falling edge
  task automatic wr(input logic [3:0] a, input logic [7:0] d,
                    input logic [3:0] s);
    logic ta, tw;
    logic tb = 1'h0;
    int n = 0;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!tb)
    begin
      @(negedge sys_clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      resp = bresp;
      @(posedge sys_clk);
      if (ta)
        awvalid <= 1'h0;
      if (tw)
        wvalid <= 1'h0;
      n++;
      if (n > 40)
        hang();
    end
    bready <= 1'h0;
  endtask

  task automatic rdr(input logic [3:0] a);
    logic ta;
    logic tr = 1'h0;
    int n = 0;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!tr)
    begin
      @(negedge sys_clk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      rd = rdata;
      resp = rresp;
      @(posedge sys_clk);
      if (ta)
        arvalid <= 1'h0;
      n++;
      if (n > 40)
        hang();
    end
    rready <= 1'h0;
  endtask

  // Pattern and drive each take one stage; wait past both
  task automatic settle();
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic pat(input logic [4:0] p);
    @(posedge sys_clk);
    pattern <= p;
    settle();
  endtask

  task automatic t_reset();
    rdr(adr_a);
    chk(rd, 32'h01);
    rdr(adr_b);
    chk(rd, 32'h00);
    chk(hv, 1'h1);
    chk(bh, 1'h1);
    chk(bl, 1'h0);
    chk(dsen, 1'h0);
    chk({oc0, oc1, oct}, 3'h4);
  endtask

  task automatic t_regs();
    wr(adr_a, 8'hFF, 4'h1);
    chk(resp, PSDS_RESP_OKAY);
    rdr(adr_a);
    chk(rd, 32'hBF);
    chk(dsen, 1'h1);
    wr(adr_b, 8'hFF, 4'h1);
    rdr(adr_b);
    chk(rd, 32'h7F);
    wr(adr_a, 8'h00, 4'h0);
    rdr(adr_a);
    chk(rd, 32'hBF);
    wr(4'h8, 8'h55, 4'h1);
    chk(resp, PSDS_RESP_SLVERR);
    rdr(4'h8);
    chk(resp, PSDS_RESP_SLVERR);
    chk(rd, 32'h00);
    wr(adr_a, 8'h00, 4'h1);
    settle();
    chk(dsen, 1'h0);
  endtask

  task automatic t_oc();
    for (int k = 0; k < 4; k++)
    begin
      wr(adr_a, 8'(k * 2), 4'h1);
      settle();
      chk({oc0, oc1, oct}, k == 0 ? 3'h4 : k == 1 ? 3'h2 : 3'h1);
    end
  endtask

  // Static mode must ignore every timer output
  task automatic t_static();
    for (int v = 0; v < 2; v++)
    begin
      wr(adr_a, 8'(v * 9), 4'h1);
      wr(adr_b, 8'(v), 4'h1);
      pat(v ? 5'h00 : 5'h1F);
      chk(lamp, v);
      chk(hv, v);
      chk({snd_a, snd_b}, v * 3);
    end
  endtask

  task automatic t_route();
    for (int s = 1; s < 4; s++)
    begin
      wr(adr_a, 8'(s * 16), 4'h1);
      wr(adr_b, 8'(s * 34), 4'h1);
      for (int k = 0; k < 3; k++)
      begin
        pat(5'(4 << k));
        chk({lamp, hv, snd_a}, s == k + 1 ? 3'h7 : 3'h0);
      end
    end
  endtask

  // Timers one and two held high must never reach the boost drive
  task automatic t_boost();
    for (int i = 0; i < 8; i++)
    begin
      wr(adr_b, 8'(i[0] * 16 + i[1] * 8), 4'h1);
      pat({3'h6, i[2], !i[2]});
      chk(bh, i[0] ? i[2] : 1'h1);
      chk(bl, i[1] ? !i[2] : 1'h0);
    end
  endtask

  task automatic t_stream();
    logic p;
    wr(adr_a, 8'h21, 4'h1);
    run <= 1'h1;
    settle();
    p = pwm_in.timer_pwm[1];
    repeat (20)
    begin
      @(negedge sys_clk);
      chk(lamp, p);
      chk(hv, 1'h1);
      p = pwm_in.timer_pwm[1];
    end
    @(posedge sys_clk);
    run <= 1'h0;
  endtask

  // Main sequence
  initial
  begin
    repeat (5) @(posedge sys_clk);
    resetn <= 1'h1;
    t_reset();
    t_regs();
    t_oc();
    t_static();
    t_route();
    t_boost();
    t_stream();
    test_done();
  end
endmodule
`default_nettype wire
